//--- test_usb_device_out_endpoint_control.sv
/*
 * Bench of the out-endpoint control block.
 * Assumes design, checker and host model compile first.
 */
`default_nettype none
`include "uoe_consts.svh"

module test_usb_device_out_endpoint_control;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] CTRL = `UOE_CTRL_ADDR;
    localparam logic [11:0] CFG = `UOE_CFG_ADDR;
    localparam logic [31:0] EN = 32'h80000000;
    localparam logic [31:0] DIS = 32'h40000000;
    localparam logic [31:0] P1 = 32'h20000000;
    localparam logic [31:0] P0 = 32'h10000000;
    localparam logic [31:0] NS = 32'h08000000;
    localparam logic [31:0] NC = 32'h04000000;
    localparam logic [31:0] ST = 32'h00200000;
    localparam logic [31:0] SN = 32'h00100000;
    localparam logic [31:0] BULK = 32'h00080000;

    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic xfer_done = 1'h0;
    logic setup_done = 1'h0;
    logic pid_advance = 1'h0;
    logic link_busy = 1'h0;
    logic rx_space = 1'h1;
    logic tx_avail = 1'h0;
    logic [31:0] hrdata, rv;
    logic hreadyout, hresp, ep_ready, setup_dma_ok, tx_nonperiodic, seen;
    logic [2:0] evts;
    logic [3:0] tx_queue;
    uoe_pkg::uoe_tok_s tok;
    uoe_pkg::uoe_rsp_s rsp;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 hclk = ~hclk;

    uoe_top #(.ADDR_W(12)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tok(tok),
        .xfer_done(xfer_done), .setup_done(setup_done),
        .pid_advance(pid_advance), .link_busy(link_busy),
        .rx_space(rx_space), .tx_avail(tx_avail), .rsp(rsp),
        .ep_ready(ep_ready), .setup_dma_ok(setup_dma_ok),
        .tx_nonperiodic(tx_nonperiodic), .tx_queue(tx_queue),
        .setup_done_evt(evts[0]), .xfer_done_evt(evts[1]),
        .ep_disabled_evt(evts[2]));

    uoe_host_model hs (.hclk(hclk), .tok(tok));

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("unexpected at %0t: timeout", $time);
            test_done;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    // one token, then the answer one cycle later
    task automatic tk(input uoe_pkg::uoe_tok_e k, input logic ok,
            input uoe_pkg::uoe_rsp_e c, input logic f);
        hs.send(k, ok);
        #1 chk(32'(rsp), 32'({1'h1, c, f}));
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rv = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        bus(1'h0, a, 32'h00000000);
    endtask

    task automatic pulse(input int w);
        @(posedge hclk);
        case (w)
            0: setup_done <= 1'h1;
            1: xfer_done <= 1'h1;
            default: pid_advance <= 1'h1;
        endcase
        @(posedge hclk);
        setup_done <= 1'h0;
        xfer_done <= 1'h0;
        pid_advance <= 1'h0;
    endtask

    task automatic got(input int w, input int n);
        seen = 1'h0;
        repeat (n) begin
            @(posedge hclk);
            if (evts[w] === 1'h1) seen = 1'h1;
        end
    endtask

    task automatic t_reset;
        rd(CTRL);
        chk(rv, 32'h00000000);
        wr(12'hB24, 32'hFFFFFFFF);
        rd(12'hB24);
        chk(rv, 32'h00000000);
        chk(tx_nonperiodic, 32'h1);
        $display("done: reset");
    endtask

    task automatic t_fields;
        for (int k = 0; k < 4; k++) begin
            wr(CTRL, 32'(k) << 18);
            rd(CTRL);
            chk(rv[19:18], 32'(k));
        end
        wr(CTRL, BULK | P1 | 32'h01400000);
        rd(CTRL);
        chk(rv, BULK | 32'h01410000);
        chk(tx_queue, 32'h5);
        chk(tx_nonperiodic, 32'h0);
        wr(CTRL, BULK);
        rd(CTRL);
        chk(rv[16], 32'h1);
        wr(CTRL, BULK | P0);
        rd(CTRL);
        chk(rv[16], 32'h0);
        pulse(2);
        rd(CTRL);
        chk(rv[16], 32'h1);
        wr(CTRL, 32'h00040000 | P0);
        rd(CTRL);
        chk(rv[16], 32'h0);
        wr(CTRL, 32'h00040000 | P1);
        rd(CTRL);
        chk(rv[16], 32'h1);
        wr(CFG, 32'h00000001);
        wr(CTRL, 32'h00040000 | P0);
        rd(CTRL);
        chk(rv[16], 32'h0);
        wr(CFG, 32'h00000000);
        $display("done: fields");
    endtask

    task automatic t_nak;
        wr(CTRL, BULK | EN | NC);
        tk(uoe_pkg::TOK_OUT, 1'h1, uoe_pkg::RSP_ACK, 1'h1);
        wr(CTRL, BULK | NS);
        rd(CTRL);
        chk(rv & ~32'h00010000, BULK | EN | 32'h00020000);
        tk(uoe_pkg::TOK_OUT, 1'h1, uoe_pkg::RSP_NAK, 1'h0);
        wr(CTRL, BULK | ST);
        tk(uoe_pkg::TOK_OUT, 1'h1, uoe_pkg::RSP_STALL, 1'h0);
        tk(uoe_pkg::TOK_IN, 1'h1, uoe_pkg::RSP_STALL, 1'h0);
        wr(CTRL, BULK);
        rd(CTRL);
        chk(rv[21], 32'h0);
        wr(CTRL, BULK | NC | SN);
        tk(uoe_pkg::TOK_OUT, 1'h0, uoe_pkg::RSP_ACK, 1'h1);
        tx_avail <= 1'h1;
        tk(uoe_pkg::TOK_IN, 1'h1, uoe_pkg::RSP_DATA, 1'h0);
        wr(CTRL, BULK);
        tk(uoe_pkg::TOK_OUT, 1'h0, uoe_pkg::RSP_NONE, 1'h0);
        $display("done: nak and stall");
    endtask

    task automatic t_setup;
        wr(CTRL, EN | ST | NC);
        wr(CTRL, 32'h00000000);
        rd(CTRL);
        chk(rv[21], 32'h1);
        tk(uoe_pkg::TOK_SETUP, 1'h1, uoe_pkg::RSP_ACK, 1'h1);
        rd(CTRL);
        chk(rv[21], 32'h0);
        chk(rv[17], 32'h1);
        pulse(0);
        got(0, 6);
        chk(seen, 32'h1);
        rd(CTRL);
        chk(rv[31], 32'h0);
        $display("done: setup");
    endtask

    task automatic t_xfer;
        wr(CFG, 32'h00000002);
        @(posedge hclk);
        #1 chk(setup_dma_ok, 32'h0);
        wr(CTRL, BULK | EN | NC);
        @(posedge hclk);
        #1 chk(setup_dma_ok, 32'h1);
        chk(ep_ready, 32'h1);
        pulse(1);
        got(1, 6);
        chk(seen, 32'h1);
        rd(CTRL);
        chk(rv[31], 32'h0);
        chk(rv[17], 32'h1);
        wr(CFG, 32'h00000000);
        $display("done: transfer");
    endtask

    task automatic t_disable;
        wr(CTRL, BULK | DIS);
        rd(CTRL);
        chk(rv[30], 32'h0);
        wr(CTRL, BULK | EN | NC);
        link_busy <= 1'h1;
        wr(CTRL, BULK | DIS);
        rd(CTRL);
        chk(rv[31:30], 32'h3);
        tk(uoe_pkg::TOK_OUT, 1'h1, uoe_pkg::RSP_NAK, 1'h0);
        got(2, 4);
        chk(seen, 32'h0);
        link_busy <= 1'h0;
        got(2, 8);
        chk(seen, 32'h1);
        rd(CTRL);
        chk(rv[31:30], 32'h0);
        $display("done: disable");
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        t_reset;
        t_fields;
        t_nak;
        t_setup;
        t_xfer;
        t_disable;
        test_done;
    end
endmodule

`default_nettype wire

//--- uoe_checker.sv
/*
 * Assertions on the ports of the out-endpoint control block.
 * Assumes one clock, hclk, and the active-low reset hresetn.
 */
`default_nettype none

module uoe_checker (
    // ahb-lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // link engine
    input wire uoe_pkg::uoe_tok_s tok,
    input wire logic xfer_done,
    input wire logic setup_done,
    input wire uoe_pkg::uoe_rsp_s rsp,
    input wire logic ep_ready,
    input wire logic setup_dma_ok,
    input wire logic tx_nonperiodic,
    input wire logic [3:0] tx_queue,
    // endpoint events
    input wire logic setup_done_evt,
    input wire logic ep_disabled_evt,
    input wire logic xfer_done_evt
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_rsp_timing: assert property (
        rsp.valid == $past(tok.valid)) else $error("answer not one cycle");
    a_setup_ack: assert property (
        tok.valid && tok.kind == uoe_pkg::TOK_SETUP |=>
        rsp.code == uoe_pkg::RSP_ACK && rsp.forward)
        else $error("setup not acked");
    a_setup_evt: assert property (
        setup_done |-> ##[1:3] setup_done_evt) else $error("no setup event");
    a_xfer_evt: assert property (
        xfer_done |-> ##[1:3] xfer_done_evt) else $error("no xfer event");
    a_xfer_clear: assert property (
        xfer_done |=> ##1 !ep_ready) else $error("enable not cleared");
    a_evt_pulse: assert property (
        setup_done_evt |=> !setup_done_evt) else $error("event too long");
    a_dis_clear: assert property (
        ep_disabled_evt |-> !ep_ready) else $error("ready at disable");
    a_queue_np: assert property (
        tx_nonperiodic |-> tx_queue == 4'h0) else $error("bad queue");
    a_dma_ok: assert property (
        ep_ready |-> setup_dma_ok) else $error("dma not allowed");
    a_read_wait: assert property (
        hsel && hready && htrans[1] && !hwrite && hsize == 3'h2 |=>
        !hreadyout ##1 hreadyout) else $error("read wait wrong");
    a_resp_okay: assert property (!hresp) else $error("response not okay");

    c_setup: cover property (tok.valid && tok.kind == uoe_pkg::TOK_SETUP);
    c_stall: cover property (rsp.valid && rsp.code == uoe_pkg::RSP_STALL);
    c_disable: cover property (ep_disabled_evt);
endmodule

bind uoe_top uoe_checker u_chk (.*);

`default_nettype wire

//--- uoe_consts.svh
/*
 * Constants of the out-endpoint control block: register offsets,
 * field positions, reset values and bus codes.
 * Assumes inclusion by the package and the design modules.
 */
`ifndef UOE_CONSTS_SVH
`define UOE_CONSTS_SVH

`define UOE_CTRL_ADDR 12'hB20
`define UOE_CFG_ADDR 12'hB28
`define UOE_ENABLE_BIT 31
`define UOE_DISABLE_BIT 30
`define UOE_PID1_BIT 29
`define UOE_PID0_BIT 28
`define UOE_NAKSET_BIT 27
`define UOE_NAKCLR_BIT 26
`define UOE_TXQ_HI 25
`define UOE_TXQ_LO 22
`define UOE_STALL_BIT 21
`define UOE_SNOOP_BIT 20
`define UOE_KIND_HI 19
`define UOE_KIND_LO 18
`define UOE_NAK_ACTIVE_BIT 17
`define UOE_PID_BIT 16
`define UOE_CFG_SG_BIT 0
`define UOE_CFG_DMA_BIT 1
`define UOE_CFG_DED_BIT 2
`define UOE_TXQ_NONPER 4'h0
`define UOE_KIND_CTRL 2'h0
`define UOE_KIND_ISO 2'h1
`define UOE_HSIZE_WORD 3'h2
`define UOE_ZERO32 32'h00000000
`define UOE_RESP_OKAY 1'h0

`endif

//--- uoe_dis.sv
/*
 * Disable sequencer: once a disable is requested, waits for the
 * link to go quiet and then gives a one-cycle done pulse.
 * Assumes link_busy is high while a packet is on the wire.
 */
`default_nettype none
`include "uoe_consts.svh"

module uoe_dis (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request and link state
    input wire logic req,
    input wire logic link_busy,
    // completion
    output logic done
);

    typedef enum logic [2:0] {
        DIS_IDLE = 3'h1,
        DIS_DRAIN = 3'h2,
        DIS_DONE = 3'h4
    } uoe_dis_e;

    uoe_dis_e state;
    uoe_dis_e next_state;
    logic next_done;

    always_comb begin
        next_state = state;
        next_done = 1'b0;
        case (state)
            DIS_IDLE: begin
                if (req) begin
                    next_state = DIS_DRAIN;
                end
            end
            DIS_DRAIN: begin
                if (!link_busy) begin
                    next_state = DIS_DONE;
                    next_done = 1'b1;
                end
            end
            DIS_DONE: begin
                next_state = DIS_IDLE;
            end
            default: begin
                next_state = DIS_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= DIS_IDLE;
            done <= 1'b0;
        end else begin
            state <= next_state;
            done <= next_done;
        end
    end

endmodule

`default_nettype wire

//--- uoe_host_model.sv
/*
 * Host-side model: issues one token to the endpoint per call.
 * Assumes the endpoint takes tokens on the rising edge of hclk.
 */
`default_nettype none

module uoe_host_model (
    // clock
    input wire logic hclk,
    // token to the endpoint
    output uoe_pkg::uoe_tok_s tok
);
    timeunit 1ns;
    timeprecision 1ps;

    initial tok = '{1'h0, uoe_pkg::TOK_IN, 1'h0};

    // valid for one cycle; idle fields differ from the last token
    task automatic send(input uoe_pkg::uoe_tok_e kind, input logic ok);
        @(posedge hclk);
        tok <= '{1'h1, kind, ok};
        @(posedge hclk);
        tok <= '{1'h0, (kind == uoe_pkg::TOK_IN) ? uoe_pkg::TOK_OUT :
            uoe_pkg::TOK_IN, ~ok};
    endtask
endmodule

`default_nettype wire

//--- uoe_hs.sv
/*
 * Handshake chooser: answers one token per cycle, registered.
 * Assumes the token struct is valid for one cycle per token.
 */
`default_nettype none
`include "uoe_consts.svh"

module uoe_hs (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // endpoint state
    input wire logic active,
    input wire logic stall,
    input wire logic nak,
    input wire logic snoop,
    input wire logic [1:0] kind,
    input wire logic rx_space,
    input wire logic tx_avail,
    // token and answer
    input wire uoe_pkg::uoe_tok_s tok,
    output uoe_pkg::uoe_rsp_s rsp
);

    uoe_pkg::uoe_rsp_s next_rsp;

    always_comb begin
        next_rsp.valid = tok.valid;
        next_rsp.code = uoe_pkg::RSP_NONE;
        next_rsp.forward = 1'b0;
        if (tok.kind == uoe_pkg::TOK_SETUP) begin
            next_rsp.code = uoe_pkg::RSP_ACK;
            next_rsp.forward = 1'b1;
        end else if (stall && !uoe_pkg::uoe_is_iso(kind)) begin
            next_rsp.code = uoe_pkg::RSP_STALL;
        end else if (uoe_pkg::uoe_is_iso(kind)) begin
            // isochronous: no handshake, data moves if it can
            next_rsp.forward = active && (tok.kind == uoe_pkg::TOK_OUT)
                && (snoop || tok.crc_ok) && rx_space;
            if (tok.kind == uoe_pkg::TOK_IN && active && tx_avail) begin
                next_rsp.code = uoe_pkg::RSP_DATA;
            end
        end else if (nak || !active) begin
            next_rsp.code = uoe_pkg::RSP_NAK;
        end else if (tok.kind == uoe_pkg::TOK_IN) begin
            next_rsp.code = tx_avail ? uoe_pkg::RSP_DATA : uoe_pkg::RSP_NAK;
        end else if (!snoop && !tok.crc_ok) begin
            next_rsp.code = uoe_pkg::RSP_NONE;
        end else if (rx_space) begin
            next_rsp.code = uoe_pkg::RSP_ACK;
            next_rsp.forward = 1'b1;
        end else begin
            next_rsp.code = uoe_pkg::RSP_NAK;
        end
        if (!tok.valid) begin
            next_rsp.code = uoe_pkg::RSP_NONE;
            next_rsp.forward = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp <= '{valid: 1'b0, code: uoe_pkg::RSP_NONE, forward: 1'b0};
        end else begin
            rsp <= next_rsp;
        end
    end

endmodule

`default_nettype wire

//--- uoe_pkg.sv
/*
 * Types shared by the out-endpoint control block.
 * Assumes uoe_consts.svh is on the include path.
 */
`default_nettype none
`include "uoe_consts.svh"

package uoe_pkg;

    typedef enum logic [2:0] {
        TOK_SETUP = 3'h1,
        TOK_OUT = 3'h2,
        TOK_IN = 3'h4
    } uoe_tok_e;

    typedef enum logic [4:0] {
        RSP_NONE = 5'h01,
        RSP_ACK = 5'h02,
        RSP_NAK = 5'h04,
        RSP_STALL = 5'h08,
        RSP_DATA = 5'h10
    } uoe_rsp_e;

    // token seen by the link engine for this endpoint
    typedef struct packed {
        logic valid;
        uoe_tok_e kind;
        logic crc_ok;
    } uoe_tok_s;

    // answer to the link engine
    typedef struct packed {
        logic valid;
        uoe_rsp_e code;
        logic forward;
    } uoe_rsp_s;

    function automatic logic uoe_is_iso(input logic [1:0] kind);
        uoe_is_iso = (kind == `UOE_KIND_ISO);
    endfunction

    function automatic logic uoe_is_ctrl(input logic [1:0] kind);
        uoe_is_ctrl = (kind == `UOE_KIND_CTRL);
    endfunction

endpackage

`default_nettype wire

//--- uoe_top.sv
/*
 * Out-endpoint control: control register behind an AHB-Lite slave,
 * enable/disable handshakes, PID and frame forcing, NAK and STALL
 * state, transmit queue choice, and the handshake chooser.
 * Assumes a link engine that reports tokens and transfer events
 * for this endpoint as one-cycle pulses on hclk.
 */
// Functional notes
// - clear enable before done/disable/complete events
// - enable means buffer ready in pointer DMA
// - enable means descriptors ready in gather DMA
// - disable stops endpoint, clears before event
// - bit 29 forces DATA1, or odd frame when sg_mode is off
// - bit 28 forces DATA0, or even frame when sg_mode is off
// - set-NAK strobe or hardware sets NAK
// - clear-NAK strobe clears NAK
// - queue number zero means non-periodic queue unless dedicated is set
// - STALL beats NAK; software-only clear for non-control kinds
// - control STALL cleared by SETUP token
// - SETUP always answered with ACK
// - snoop forwards OUT data unchecked
// - transfer kind codes 00 01 10 11
// - NAK status bit refuses OUT data of non-isochronous kinds
// - read-only data PID bit, DATA0 or DATA1; odd/even frame for isochronous, 0 with sg_mode on
`default_nettype none
`include "uoe_consts.svh"

module uoe_top #(
    parameter int ADDR_W = 12
) (
    // ahb-lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // link engine events
    input wire uoe_pkg::uoe_tok_s tok,
    input wire logic xfer_done,
    input wire logic setup_done,
    input wire logic pid_advance,
    input wire logic link_busy,
    input wire logic rx_space,
    input wire logic tx_avail,
    // link engine answers
    output uoe_pkg::uoe_rsp_s rsp,
    output logic ep_ready,
    output logic setup_dma_ok,
    output logic tx_nonperiodic,
    output logic [3:0] tx_queue,
    // endpoint events
    output logic setup_done_evt,
    output logic ep_disabled_evt,
    output logic xfer_done_evt
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic endpoint_enable, next_endpoint_enable;
    logic endpoint_disable_request, next_endpoint_disable_request;
    logic nak, next_nak;
    logic stall, next_stall;
    logic snoop, next_snoop;
    logic [1:0] transfer_kind, next_transfer_kind;
    logic [3:0] tx_queue_select, next_tx_queue_select;
    logic toggle_pid, next_toggle_pid;
    logic frame_parity, next_frame_parity;
    logic sg_mode, next_sg_mode;
    logic dma_mode, next_dma_mode;
    logic dedicated, next_dedicated;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    logic wr_q, next_wr_q;
    logic rd_q, next_rd_q;
    logic [ADDR_W-1:0] addr_q, next_addr_q;
    logic [31:0] next_hrdata;
    logic next_hreadyout;
    logic take;
    logic [31:0] ctrl_view;
    logic [31:0] cfg_view;
    logic wr_ctrl, wr_cfg;
    logic dis_done;
    logic evt_setup_p, evt_dis_p, evt_xfer_p;
    logic next_evt_setup_p, next_evt_dis_p, next_evt_xfer_p;

    assign take = hsel && hready && htrans[1] && (hsize == `UOE_HSIZE_WORD);
    assign wr_ctrl = wr_q && (addr_q == `UOE_CTRL_ADDR);
    assign wr_cfg = wr_q && (addr_q == `UOE_CFG_ADDR);

    always_comb begin
        ctrl_view = `UOE_ZERO32;
        ctrl_view[`UOE_ENABLE_BIT] = endpoint_enable;
        ctrl_view[`UOE_DISABLE_BIT] = endpoint_disable_request;
        ctrl_view[`UOE_TXQ_HI:`UOE_TXQ_LO] = tx_queue_select;
        ctrl_view[`UOE_STALL_BIT] = stall;
        ctrl_view[`UOE_SNOOP_BIT] = snoop;
        ctrl_view[`UOE_KIND_HI:`UOE_KIND_LO] = transfer_kind;
        ctrl_view[`UOE_NAK_ACTIVE_BIT] = nak;
        ctrl_view[`UOE_PID_BIT] = uoe_pkg::uoe_is_iso(transfer_kind)
            ? (frame_parity && !sg_mode) : toggle_pid;
        cfg_view = `UOE_ZERO32;
        cfg_view[`UOE_CFG_SG_BIT] = sg_mode;
        cfg_view[`UOE_CFG_DMA_BIT] = dma_mode;
        cfg_view[`UOE_CFG_DED_BIT] = dedicated;
    end

    // reads take one wait state so a write just before is seen
    always_comb begin
        next_wr_q = take && hwrite;
        next_rd_q = take && !hwrite;
        next_addr_q = take ? haddr : addr_q;
        next_hreadyout = !(take && !hwrite);
        next_hrdata = hrdata;
        if (rd_q) begin
            if (addr_q == `UOE_CTRL_ADDR) begin
                next_hrdata = ctrl_view;
            end else if (addr_q == `UOE_CFG_ADDR) begin
                next_hrdata = cfg_view;
            end else begin
                next_hrdata = `UOE_ZERO32;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= '0;
            hrdata <= `UOE_ZERO32;
            hreadyout <= 1'b1;
            hresp <= `UOE_RESP_OKAY;
        end else begin
            wr_q <= next_wr_q;
            rd_q <= next_rd_q;
            addr_q <= next_addr_q;
            hrdata <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp <= `UOE_RESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // control register next state
    // ------------------------------------------------------------
    always_comb begin
        next_endpoint_enable = endpoint_enable;
        next_endpoint_disable_request = endpoint_disable_request;
        next_nak = nak;
        next_stall = stall;
        next_snoop = snoop;
        next_transfer_kind = transfer_kind;
        next_tx_queue_select = tx_queue_select;
        next_toggle_pid = toggle_pid;
        next_frame_parity = frame_parity;
        next_sg_mode = sg_mode;
        next_dma_mode = dma_mode;
        next_dedicated = dedicated;
        if (pid_advance) begin
            next_toggle_pid = !toggle_pid;
        end
        // hardware clears first so a write in the same cycle wins
        if (tok.valid && tok.kind == uoe_pkg::TOK_SETUP
            && uoe_pkg::uoe_is_ctrl(transfer_kind)) begin
            next_stall = 1'b0;
        end
        if (setup_done || xfer_done || dis_done) begin
            next_endpoint_enable = 1'b0;
        end
        if (dis_done) begin
            next_endpoint_disable_request = 1'b0;
        end
        if (wr_ctrl) begin
            next_endpoint_enable = hwdata[`UOE_ENABLE_BIT]
                || (endpoint_enable && next_endpoint_enable);
            if (hwdata[`UOE_DISABLE_BIT] && endpoint_enable) begin
                next_endpoint_disable_request = 1'b1;
            end
            if (hwdata[`UOE_NAKCLR_BIT]) begin
                next_nak = 1'b0;
            end
            if (hwdata[`UOE_NAKSET_BIT]) begin
                next_nak = 1'b1;
            end
            if (hwdata[`UOE_STALL_BIT]) begin
                next_stall = 1'b1;
            end else if (!uoe_pkg::uoe_is_ctrl(transfer_kind)) begin
                next_stall = 1'b0;
            end
            next_snoop = hwdata[`UOE_SNOOP_BIT];
            next_transfer_kind = hwdata[`UOE_KIND_HI:`UOE_KIND_LO];
            next_tx_queue_select = hwdata[`UOE_TXQ_HI:`UOE_TXQ_LO];
            if (!uoe_pkg::uoe_is_iso(transfer_kind)) begin
                if (hwdata[`UOE_PID1_BIT]) begin
                    next_toggle_pid = 1'b1;
                end else if (hwdata[`UOE_PID0_BIT]) begin
                    next_toggle_pid = 1'b0;
                end
            end else if (!sg_mode) begin
                if (hwdata[`UOE_PID1_BIT]) begin
                    next_frame_parity = 1'b1;
                end else if (hwdata[`UOE_PID0_BIT]) begin
                    next_frame_parity = 1'b0;
                end
            end
        end
        // hardware NAK set beats a software clear
        if (setup_done || (xfer_done && !uoe_pkg::uoe_is_iso(transfer_kind))
            || (tok.valid && tok.kind == uoe_pkg::TOK_SETUP)) begin
            next_nak = 1'b1;
        end
        if (wr_cfg) begin
            next_sg_mode = hwdata[`UOE_CFG_SG_BIT];
            next_dma_mode = hwdata[`UOE_CFG_DMA_BIT];
            next_dedicated = hwdata[`UOE_CFG_DED_BIT];
        end
        next_evt_setup_p = setup_done;
        next_evt_dis_p = dis_done;
        next_evt_xfer_p = xfer_done;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            endpoint_enable <= 1'b0;
            endpoint_disable_request <= 1'b0;
            nak <= 1'b0;
            stall <= 1'b0;
            snoop <= 1'b0;
            transfer_kind <= `UOE_KIND_CTRL;
            tx_queue_select <= `UOE_TXQ_NONPER;
            toggle_pid <= 1'b0;
            frame_parity <= 1'b0;
            sg_mode <= 1'b0;
            dma_mode <= 1'b0;
            dedicated <= 1'b0;
            evt_setup_p <= 1'b0;
            evt_dis_p <= 1'b0;
            evt_xfer_p <= 1'b0;
        end else begin
            endpoint_enable <= next_endpoint_enable;
            endpoint_disable_request <= next_endpoint_disable_request;
            nak <= next_nak;
            stall <= next_stall;
            snoop <= next_snoop;
            transfer_kind <= next_transfer_kind;
            tx_queue_select <= next_tx_queue_select;
            toggle_pid <= next_toggle_pid;
            frame_parity <= next_frame_parity;
            sg_mode <= next_sg_mode;
            dma_mode <= next_dma_mode;
            dedicated <= next_dedicated;
            evt_setup_p <= next_evt_setup_p;
            evt_dis_p <= next_evt_dis_p;
            evt_xfer_p <= next_evt_xfer_p;
        end
    end

    // ------------------------------------------------------------
    // link-facing outputs
    // ------------------------------------------------------------
    // events rise one cycle after enable has already dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setup_done_evt <= 1'b0;
            ep_disabled_evt <= 1'b0;
            xfer_done_evt <= 1'b0;
            ep_ready <= 1'b0;
            setup_dma_ok <= 1'b0;
            tx_nonperiodic <= 1'b1;
            tx_queue <= `UOE_TXQ_NONPER;
        end else begin
            setup_done_evt <= evt_setup_p;
            ep_disabled_evt <= evt_dis_p;
            xfer_done_evt <= evt_xfer_p;
            ep_ready <= endpoint_enable
                && !endpoint_disable_request;
            setup_dma_ok <= !dma_mode || endpoint_enable;
            tx_nonperiodic <= !dedicated
                && (tx_queue_select == `UOE_TXQ_NONPER);
            tx_queue <= tx_queue_select;
        end
    end

    uoe_dis u_dis (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(endpoint_disable_request && endpoint_enable),
        .link_busy(link_busy),
        .done(dis_done)
    );

    uoe_hs u_hs (
        .hclk(hclk),
        .hresetn(hresetn),
        .active(endpoint_enable && !endpoint_disable_request),
        .stall(stall),
        .nak(nak),
        .snoop(snoop),
        .kind(transfer_kind),
        .rx_space(rx_space),
        .tx_avail(tx_avail),
        .tok(tok),
        .rsp(rsp)
    );

endmodule

`default_nettype wire
